// ### bench/fbled_node.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Managing node: pulses one bus event per request and holds the error level.
module fbled_node (
  input wire logic i_sys_clk,
  output var fbled_pkg::fbled_bus_ev_t o_ev
);
  import fbled_pkg::*;
  logic err_q;
  initial begin
    err_q = 1'b0;
    o_ev = '0;
  end
  task automatic send(input int idx);
    @(negedge i_sys_clk);
    o_ev = fbled_bus_ev_t'((8'h80 >> idx) | {7'h00, err_q});
    @(negedge i_sys_clk);
    o_ev = fbled_bus_ev_t'({7'h00, err_q});
  endtask : send
  task automatic set_err(input logic e);
    @(negedge i_sys_clk);
    err_q = e;
    o_ev = fbled_bus_ev_t'({7'h00, e});
  endtask : set_err
endmodule : fbled_node
`default_nettype wire

// ### bench/fbled_props.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Checker on the ports of the indicator block.
module fbled_props #(
  parameter int unsigned NUM_PORTS = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire fbled_pkg::fbled_health_t i_health,
  input wire logic i_bus_powered,
  input wire fbled_pkg::fbled_bus_ev_t i_bus_ev,
  input wire logic [NUM_PORTS-1:0] i_link_up,
  input wire logic [NUM_PORTS-1:0] i_link_act,
  input wire fbled_pkg::fbled_led_t o_power_led,
  input wire fbled_pkg::fbled_led_t o_state_led,
  input wire logic [NUM_PORTS-1:0] o_link_led,
  input wire fbled_pkg::fbled_nmt_t o_nmt_state,
  input wire logic o_out_data_en,
  input wire logic o_in_data_en
);
  import fbled_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence s_pwr;
    (i_bus_powered && i_ce)[*3];
  endsequence
  a_data_gate: assert property (
    (o_out_data_en |-> o_nmt_state == NMT_RUNNING_STATE) and
    (o_nmt_state == NMT_HALTED_STATE |-> !o_in_data_en)) else $error("data enable wrong for state");
  a_halt_enter: assert property (
    $rose(o_nmt_state == NMT_HALTED_STATE) |-> $past(i_bus_ev.cmd_stop)) else $error("halted without stop");
  a_halt_leave: assert property (
    $fell(o_nmt_state == NMT_HALTED_STATE) |-> $past(i_bus_ev.cmd_enter_preop || i_bus_ev.cmd_reset)
    || !$past(i_bus_powered, 3)) else $error("halted left without command");
  a_err_red: assert property (
    i_ce && i_bus_ev.bus_error && o_nmt_state != NMT_OFF |=> o_state_led == 2'h1) else $error("error not red");
  a_run_green: assert property (
    (i_ce && o_nmt_state == NMT_RUNNING_STATE && !i_bus_ev.bus_error)[*2] |=> o_state_led == 2'h2)
    else $error("running not green");
  a_off_dark: assert property (
    (i_ce && o_nmt_state == NMT_OFF)[*2] |=> o_state_led == 2'h0) else $error("state led lit when off");
  a_pwr_dark: assert property (
    i_ce && !i_health.running |=> o_power_led == 2'h0) else $error("power led lit when not running");
  a_pwr_serious: assert property (
    i_ce && i_health.running && i_health.serious_err |=> o_power_led == 2'h1) else $error("serious not red");
  a_link_dark: assert property (
    (i_ce && !i_link_up[0])[*4] |=> !o_link_led[0]) else $error("link led lit without link");
  a_traffic_step: assert property (
    s_pwr ##0 (o_nmt_state == NMT_NOT_ACTIVE && i_bus_ev.traffic && !i_bus_ev.cmd_reset)
    |=> o_nmt_state == NMT_PREOP_FIRST) else $error("traffic did not advance");
  a_soc_step: assert property (
    s_pwr ##0 (o_nmt_state == NMT_PREOP_FIRST && i_bus_ev.soc_frame && !i_bus_ev.cmd_stop
    && !i_bus_ev.cmd_reset) |=> o_nmt_state == NMT_PREOP_SECOND) else $error("cycle start did not advance");
endmodule : fbled_props
bind fbled_top fbled_props #(.NUM_PORTS(NUM_PORTS)) u_props (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_ce(i_ce), .i_health(i_health), .i_bus_powered(i_bus_powered), .i_bus_ev(i_bus_ev),
  .i_link_up(i_link_up), .i_link_act(i_link_act), .o_power_led(o_power_led), .o_state_led(o_state_led),
  .o_link_led(o_link_led), .o_nmt_state(o_nmt_state), .o_out_data_en(o_out_data_en),
  .o_in_data_en(o_in_data_en));
`default_nettype wire

// ### bench/fbled_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench with a behavioural state model.
module fbled_top_tb_top;
  import fbled_pkg::*;
  localparam int WIN = 352;
  logic i_sys_clk, i_reset, i_ce, i_bus_powered;
  fbled_health_t i_health;
  fbled_bus_ev_t ev;
  logic [1:0] i_link_up, i_link_act, o_link_led;
  fbled_led_t o_power_led, o_state_led;
  fbled_nmt_t o_nmt_state;
  logic o_out_data_en, o_in_data_en;
  logic [4:0] cur, prev;
  int err_count, n_tests, seed, st, b;
  int cnt[5];
  fbled_top #(.NUM_PORTS(2), .TICK_CYC(4), .ACT_HOLD(2)) DUT (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_ce(i_ce), .i_health(i_health), .i_bus_powered(i_bus_powered), .i_bus_ev(ev), .i_link_up(i_link_up),
    .i_link_act(i_link_act), .o_power_led(o_power_led), .o_state_led(o_state_led), .o_link_led(o_link_led),
    .o_nmt_state(o_nmt_state), .o_out_data_en(o_out_data_en), .o_in_data_en(o_in_data_en));
  fbled_node node (.i_sys_clk(i_sys_clk), .o_ev(ev));
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic close_out;
    $display("mismatches=%0d comparisons=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  // Counts rising edges of each power and state lamp and of link lamp 0 over a window that spans whole pattern periods.
  task automatic win;
    repeat (2) @(negedge i_sys_clk);
    prev = {o_power_led, o_state_led, o_link_led[0]};
    cnt = '{default: 0};
    repeat (WIN) begin
      @(negedge i_sys_clk);
      cur = {o_power_led, o_state_led, o_link_led[0]};
      for (int k = 0; k < 5; k++) begin
        cnt[k] += int'(cur[k] && !prev[k]);
      end
      prev = cur;
    end
  endtask : win
  function automatic int nxt(input int s, input int i);
    return (i == 6 && s != 0) ? 1 : (i == 4 && s > 1 && s < 6) ? 6 : (i == 0 && s == 1) ? 2 :
      (i == 1 && s == 2) ? 3 : (i == 2 && s == 3) ? 4 : (i == 3 && s == 4) ? 5 : (i == 5 && s > 4) ? 3 : s;
  endfunction : nxt
  task automatic step(input int idx);
    node.send(idx);
    st = nxt(st, idx);
    check(o_nmt_state, st);
    check(o_out_data_en, st == 5);
    check(o_in_data_en, st == 4 || st == 5);
  endtask : step
  task automatic pwr(input fbled_health_t h, input int eg, input int er, input logic [2:0] fin);
    i_health = h;
    win();
    check(cnt[4], eg);
    check(cnt[3], er);
    if (fin[2]) begin
      check(o_power_led, fin[1:0]);
    end
  endtask : pwr
  initial begin
    seed = 44;
    err_count = 0;
    n_tests = 0;
    st = 0;
    i_reset = 1'b1;
    i_ce = 1'b1;
    i_bus_powered = 1'b0;
    i_health = '0;
    i_link_up = 2'b00;
    i_link_act = 2'b00;
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_reset = 1'b0;
    check(o_nmt_state, 0);
    repeat (6) @(negedge i_sys_clk);
    i_link_up = 2'b11;
    i_link_act = 2'b01;
    pwr(4'b0000, 0, 0, 3'b100);
    pwr(4'b1000, 11, 0, 3'b000);
    pwr(4'b1100, 0, 0, 3'b110);
    pwr(4'b1110, 0, 2, 3'b000);
    pwr(4'b1111, 0, 0, 3'b101);
    check(cnt[0], 11);
    check(o_link_led[1], 1);
    check(cnt[2], 0);
    check(o_state_led, 0);
    i_link_up = 2'b00;
    repeat (5) @(negedge i_sys_clk);
    check(o_link_led, 0);
    i_bus_powered = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    st = 1;
    check(o_nmt_state, st);
    win();
    check(cnt[2], 44);
    step(0);
    win();
    check(cnt[2], 2);
    step(1);
    win();
    check(cnt[2], 4);
    step(2);
    win();
    check(cnt[2], 6);
    step(3);
    win();
    check(o_state_led, 2'h2);
    node.set_err(1'b1);
    repeat (2) @(negedge i_sys_clk);
    check(o_state_led, 2'h1);
    node.set_err(1'b0);
    repeat (2) @(negedge i_sys_clk);
    check(o_state_led, 2'h2);
    step(4);
    win();
    check(cnt[2], 11);
    cur = {o_power_led, o_state_led, o_link_led[0]};
    i_ce = 1'b0;
    repeat (40) @(negedge i_sys_clk);
    check({o_power_led, o_state_led, o_link_led[0]}, cur);
    check(o_nmt_state, st);
    i_ce = 1'b1;
    for (int k = 0; k < 60; k++) begin
      b = (($random(seed) % 7) + 7) % 7;
      step(b);
    end
    i_bus_powered = 1'b0;
    repeat (5) @(negedge i_sys_clk);
    check(o_nmt_state, 0);
    check(o_state_led, 0);
    close_out();
  end
endmodule : fbled_top_tb_top
`default_nettype wire

// ### rtl/fbled_pkg.sv
package fbled_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned TICK_TIME_MS = 50;
  localparam int unsigned TICK_CYCLES = TICK_TIME_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int unsigned FLICKER_TICKS = 1;
  localparam int unsigned BLINK_TICKS = 4;
  localparam int unsigned FLASH_ON_TICKS = 4;
  localparam int unsigned FLASH_GAP_TICKS = 4;
  localparam int unsigned FLASH_PAUSE_TICKS = 20;
  localparam int unsigned ACT_HOLD_TICKS = 8;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    NMT_OFF = 3'b000,
    NMT_NOT_ACTIVE = 3'b001,
    NMT_PREOP_FIRST = 3'b010,
    NMT_PREOP_SECOND = 3'b011,
    NMT_READY_STATE = 3'b100,
    NMT_RUNNING_STATE = 3'b101,
    NMT_HALTED_STATE = 3'b110
  } fbled_nmt_t;

  typedef struct packed {
    logic green;
    logic red;
  } fbled_led_t;

  typedef struct packed {
    logic traffic;
    logic soc_frame;
    logic configured;
    logic cmd_start;
    logic cmd_stop;
    logic cmd_enter_preop;
    logic cmd_reset;
    logic bus_error;
  } fbled_bus_ev_t;

  typedef struct packed {
    logic running;
    logic init_done;
    logic correctable_err;
    logic serious_err;
  } fbled_health_t;

  typedef struct packed {
    logic flicker;
    logic blink;
    logic flash1;
    logic flash2;
    logic flash3;
  } fbled_pat_t;
endpackage : fbled_pkg

// ### rtl/fbled_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fbled_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  if (WIDTH < 1) begin : g_bad_width
    $error("fbled_sync: WIDTH must be at least 1");
  end

  // ==========================================================================
  // Two-stage synchroniser
  // ==========================================================================
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (i_ce) begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule : fbled_sync
`default_nettype wire

// ### rtl/fbled_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module fbled_timebase #(
  parameter int unsigned TICK_CYC = fbled_pkg::TICK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  output logic o_tick,
  output fbled_pkg::fbled_pat_t o_pat
);
  import fbled_pkg::*;

  localparam int unsigned PERIOD = 6 * FLASH_ON_TICKS + FLASH_PAUSE_TICKS;

  if (TICK_CYC < 2) begin : g_bad_tick
    $error("fbled_timebase: TICK_CYC must be at least 2");
  end

  // ==========================================================================
  // Shared tick and pattern phase
  // ==========================================================================
  logic [31:0] div_q;
  logic [7:0] phase_q;
  logic [3:0] blink_q;
  fbled_pat_t pat_q;
  wire tick = (div_q == TICK_CYC - 1);
  wire [7:0] ph_next = (phase_q == 8'(PERIOD - 1)) ? 8'h00 : phase_q + 8'h01;
  wire [3:0] bl_next = (blink_q == 4'(2 * BLINK_TICKS - 1)) ? 4'h0 : blink_q + 4'h1;

  function automatic logic flash_on(input logic [7:0] ph, input int unsigned n);
    int unsigned slot;
    slot = ph / (FLASH_ON_TICKS + FLASH_GAP_TICKS);
    flash_on = (slot < n) && ((ph % (FLASH_ON_TICKS + FLASH_GAP_TICKS)) < FLASH_ON_TICKS);
  endfunction : flash_on

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      div_q <= 32'h0;
      phase_q <= 8'h00;
      blink_q <= 4'h0;
      pat_q <= '0;
    end else if (i_ce) begin
      div_q <= tick ? 32'h0 : div_q + 32'h1;
      if (tick) begin
        phase_q <= ph_next;
        blink_q <= bl_next;
        pat_q.flicker <= ~pat_q.flicker;
        pat_q.blink <= (bl_next < 4'(BLINK_TICKS));
        pat_q.flash1 <= flash_on(ph_next, 1);
        pat_q.flash2 <= flash_on(ph_next, 2);
        pat_q.flash3 <= flash_on(ph_next, 3);
      end
    end
  end

  assign o_tick = tick & i_ce;
  assign o_pat = pat_q;
endmodule : fbled_timebase
`default_nettype wire

// ### rtl/fbled_top.sv
`timescale 1ns/1ps
`default_nettype none
module fbled_top #(
  parameter int unsigned NUM_PORTS = 2,
  parameter int unsigned TICK_CYC = fbled_pkg::TICK_CYCLES,
  parameter int unsigned ACT_HOLD = fbled_pkg::ACT_HOLD_TICKS
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire fbled_pkg::fbled_health_t i_health,
  input wire logic i_bus_powered,
  input wire fbled_pkg::fbled_bus_ev_t i_bus_ev,
  input wire logic [NUM_PORTS-1:0] i_link_up,
  input wire logic [NUM_PORTS-1:0] i_link_act,
  output fbled_pkg::fbled_led_t o_power_led,
  output fbled_pkg::fbled_led_t o_state_led,
  output logic [NUM_PORTS-1:0] o_link_led,
  output fbled_pkg::fbled_nmt_t o_nmt_state,
  output logic o_out_data_en,
  output logic o_in_data_en
);
  import fbled_pkg::*;

  // ==========================================================================
  // Configuration checks
  // ==========================================================================
  if (NUM_PORTS < 1 || NUM_PORTS > 16) begin : g_bad_ports
    $error("fbled_top: NUM_PORTS must be 1 to 16");
  end
  if (ACT_HOLD < 1 || ACT_HOLD > 255) begin : g_bad_hold
    $error("fbled_top: ACT_HOLD must be 1 to 255");
  end
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("fbled_top: TICK_CYC must be at least 2");
  end

  // ==========================================================================
  // Timebase
  // ==========================================================================
  logic tick;
  fbled_pat_t pat;

  fbled_timebase #(
    .TICK_CYC(TICK_CYC)
  ) u_timebase (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .o_tick(tick),
    .o_pat(pat)
  );

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  localparam int unsigned SYNC_W = 2 * NUM_PORTS + 1;
  logic [SYNC_W-1:0] sync_out;

  fbled_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_async({i_bus_powered, i_link_up, i_link_act}),
    .o_sync(sync_out)
  );

  wire bus_powered = sync_out[SYNC_W-1];
  wire [NUM_PORTS-1:0] link_up = sync_out[2*NUM_PORTS-1:NUM_PORTS];
  wire [NUM_PORTS-1:0] link_act = sync_out[NUM_PORTS-1:0];

  // ==========================================================================
  // Power indicator
  // ==========================================================================
  fbled_led_t power_d;
  fbled_led_t power_q;

  always_comb begin
    power_d = '0;
    if (!i_health.running) begin
      power_d = '0;
    end else if (i_health.serious_err) begin
      power_d.red = 1'b1;
    end else if (i_health.correctable_err) begin
      power_d.red = pat.flash1;
    end else if (!i_health.init_done) begin
      power_d.green = pat.blink;
    end else begin
      power_d.green = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      power_q <= '0;
    end else if (i_ce) begin
      power_q <= power_d;
    end
  end

  assign o_power_led = power_q;

  // ==========================================================================
  // Link activity indicators
  // ==========================================================================
  wire [NUM_PORTS-1:0] link_led;

  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [7:0] hold_q;
      logic led_q;
      wire busy = (hold_q != 8'h00);

      always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
          hold_q <= 8'h00;
          led_q <= 1'b0;
        end else if (i_ce) begin
          if (!link_up[p]) begin
            hold_q <= 8'h00;
          end else if (link_act[p]) begin
            hold_q <= 8'(ACT_HOLD);
          end else if (tick && busy) begin
            hold_q <= hold_q - 8'h01;
          end
          led_q <= link_up[p] & (busy ? pat.blink : 1'b1);
        end
      end

      assign link_led[p] = led_q;
    end
  endgenerate

  assign o_link_led = link_led;

  // ==========================================================================
  // Network management state machine
  // ==========================================================================
  fbled_nmt_t nmt_q;
  fbled_nmt_t nmt_d;

  always_comb begin
    nmt_d = nmt_q;
    if (!bus_powered) begin
      nmt_d = NMT_OFF;
    end else if (i_bus_ev.cmd_reset) begin
      nmt_d = NMT_NOT_ACTIVE;
    end else begin
      case (nmt_q)
        NMT_OFF: begin
          nmt_d = NMT_NOT_ACTIVE;
        end
        NMT_NOT_ACTIVE: begin
          if (i_bus_ev.traffic) begin
            nmt_d = NMT_PREOP_FIRST;
          end
        end
        NMT_PREOP_FIRST: begin
          if (i_bus_ev.cmd_stop) begin
            nmt_d = NMT_HALTED_STATE;
          end else if (i_bus_ev.soc_frame) begin
            nmt_d = NMT_PREOP_SECOND;
          end
        end
        NMT_PREOP_SECOND: begin
          if (i_bus_ev.cmd_stop) begin
            nmt_d = NMT_HALTED_STATE;
          end else if (i_bus_ev.configured) begin
            nmt_d = NMT_READY_STATE;
          end
        end
        NMT_READY_STATE: begin
          if (i_bus_ev.cmd_stop) begin
            nmt_d = NMT_HALTED_STATE;
          end else if (i_bus_ev.cmd_start) begin
            nmt_d = NMT_RUNNING_STATE;
          end
        end
        NMT_RUNNING_STATE: begin
          if (i_bus_ev.cmd_stop) begin
            nmt_d = NMT_HALTED_STATE;
          end else if (i_bus_ev.cmd_enter_preop) begin
            nmt_d = NMT_PREOP_SECOND;
          end
        end
        NMT_HALTED_STATE: begin
          if (i_bus_ev.cmd_enter_preop) begin
            nmt_d = NMT_PREOP_SECOND;
          end
        end
        default: begin
          nmt_d = NMT_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      nmt_q <= NMT_OFF;
    end else if (i_ce) begin
      nmt_q <= nmt_d;
    end
  end

  assign o_nmt_state = nmt_q;

  // ==========================================================================
  // State and error indicator
  // ==========================================================================
  fbled_led_t state_d;
  fbled_led_t state_q;
  logic out_en_q;
  logic in_en_q;

  always_comb begin
    state_d = '0;
    if (nmt_q == NMT_OFF) begin
      state_d = '0;
    end else if (i_bus_ev.bus_error) begin
      state_d.red = 1'b1;
    end else begin
      case (nmt_q)
        NMT_PREOP_FIRST: state_d.green = pat.flash1;
        NMT_PREOP_SECOND: state_d.green = pat.flash2;
        NMT_READY_STATE: state_d.green = pat.flash3;
        NMT_RUNNING_STATE: state_d.green = 1'b1;
        NMT_HALTED_STATE: state_d.green = pat.blink;
        default: state_d = '0;
      endcase
    end
    if (nmt_q == NMT_NOT_ACTIVE && !i_bus_ev.bus_error) begin
      state_d.green = pat.flicker;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q <= '0;
      out_en_q <= 1'b0;
      in_en_q <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
      out_en_q <= (nmt_d == NMT_RUNNING_STATE);
      in_en_q <= (nmt_d == NMT_RUNNING_STATE) || (nmt_d == NMT_READY_STATE);
    end
  end

  assign o_state_led = state_q;
  assign o_out_data_en = out_en_q;
  assign o_in_data_en = in_en_q;
endmodule : fbled_top
`default_nettype wire
